//--- logic/bit_alu.sv
`default_nettype none
module bit_alu
  import bit_branch_pkg::*;
(
  // Operation
  input wire bitop_type op,
  input wire logic [2:0] sel,
  input wire logic inv,
  input wire logic carry,
  // Operand byte
  input wire logic [7:0] data,
  // Results
  output logic carry_out,
  output logic [7:0] data_out
);

  logic bit_val;
  logic new_bit;

  // Selected bit, complemented for the inverted forms
  assign bit_val = data[sel] ^ inv;

  // Carry result of the carry-bit group
  assign carry_out = (op == BO_AND) ? (carry & bit_val) :
                     (op == BO_OR) ? (carry | bit_val) :
                     (op == BO_XOR) ? (carry ^ bit_val) :
                     (op == BO_LD) ? bit_val : carry;

  // New value of the selected bit; others pass through
  assign new_bit = (op == BO_ST) ? carry :
                   (op == BO_SET) ? 1'b1 :
                   (op == BO_CLR) ? 1'b0 :
                   (op == BO_NOT) ? ~data[sel] : data[sel];

  for (genvar k = 0; k < 8; k++) begin : g_bit
    assign data_out[k] = (sel == 3'(k)) ? new_bit : data[k];
  end

endmodule
`default_nettype wire

//--- logic/bit_branch_exec.sv
// Function
// - Carry-AND bit: C = C and (inverted) bit
// - Carry-OR bit: C = C or (inverted) bit
// - Carry-XOR bit: C = C xor (inverted) bit
// - Carry-load bit: C = bit or its complement
// - Carry-store writes C to bit, flags kept
// - Bit test: Z=A&M zero, N=M7, V=M6
// - Direct-page bit clear, flags unchanged
// - Direct-page bit set, flags unchanged
// - Bit complement in place, flags unchanged
// - Accumulator bit set or clear, two cycles
// - One-byte carry, G, overflow flag operations
// - Test-and-clear: NZ from A-M, M=M&~A
// - Test-and-set: NZ from A-M, M=M|A
// - Branch on bit high or low, 4/6 or 5/7
// - Carry branches, 2/4 cycles
// - Zero-flag branches on Z one or zero
// - Sign branches on N one or zero
`default_nettype none
module bit_branch_exec
  import bit_branch_pkg::*;
#(
  parameter int PADDR_W = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Instruction from fetch/decode
  input wire logic instr_valid,
  output logic instr_ready,
  input wire instr_type instr_in,
  // Completion and branch redirect
  output logic done,
  output logic redirect,
  output logic [15:0] target_pc,
  // Data memory, read data one cycle after mem_rd
  output logic mem_rd,
  output logic mem_wr,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Core state
  output psw_type psw,
  output logic [7:0] acc,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr
);

  if (PADDR_W < 4) begin : g_chk
    $error("PADDR_W too small for the register map");
  end

  state_type state, next_state;
  cls_type cls_in, cls_q;
  bitop_type aluop_in, aluop_q;
  logic [3:0] cnt, cyc_base;
  logic [7:0] opc_q, rel_q, last_opc;
  logic [15:0] pc_next_q;
  logic [2:0] bsel_in, bsel_q;
  logic inv_in, inv_q, taken_q, ctrl_en, unknown_q;
  logic accept, imm_taken, dbr_taken, fbr_cond, flag_upd, acc_upd, writes;
  logic [ADDR_W-1:0] dp_addr, abs_addr, cbit_addr, addr_in;
  logic [7:0] opc, lo_rel, hi_rel, rel_in, diff, acc_new;
  logic [3:0] lo;
  logic xbit_low, is_cbit;
  logic alu_carry;
  logic [7:0] alu_data;
  psw_type next_psw;
  logic apb_hit, apb_wr, apb_setup;
  logic [7:0] apb_off;
  logic [DATA_W-1:0] rd_mux;

  assign opc = instr_in.opcode;
  assign lo = opc[3:0];
  assign xbit_low = opc[4];  // Odd upper nibble selects the clear / branch-on-low form

  // Bit number and operand addresses at decode
  assign is_cbit = (opc == OP_CAND) || (opc == OP_COR) || (opc == OP_CXOR) ||
                   (opc == OP_CLD) || (opc == OP_CST) || (opc == OP_CNOT);
  assign bsel_in = is_cbit ? instr_in.op2[BSEL_HI:BSEL_LO] : opc[7:5];
  assign inv_in = instr_in.op2[INV_POS] &
                  ((opc == OP_CAND) | (opc == OP_COR) | (opc == OP_CXOR) | (opc == OP_CLD));
  // G selects the direct page, so the direct-page byte reaches page 0 or 1
  assign dp_addr = {7'h00, psw.g, instr_in.op1};
  assign abs_addr = {instr_in.op2, instr_in.op1};
  assign cbit_addr = {4'h0, instr_in.op2[BADDR_HI:0], instr_in.op1};
  assign addr_in = (cls_in == CL_CBIT) ? cbit_addr :
                   ((cls_in == CL_BIT && opc == OP_BITABS) || cls_in == CL_TCLR ||
                    cls_in == CL_TSET) ? abs_addr : dp_addr;

  // Opcode classification
  assign cls_in = is_cbit ? CL_CBIT :
                  (lo == NIB_MBIT) ? CL_MBIT :
                  (lo == NIB_ABR) ? CL_ABR :
                  (lo == NIB_DBR) ? CL_DBR :
                  (opc == OP_ASET || opc == OP_ACLR) ? CL_ABIT :
                  (opc == OP_BITDP || opc == OP_BITABS) ? CL_BIT :
                  (opc == OP_TCLR) ? CL_TCLR :
                  (opc == OP_TSET) ? CL_TSET :
                  (opc == OP_CARRY_CLEAR_OP || opc == OP_CARRY_SET_OP || opc == OP_G_FLAG_CLEAR_OP ||
                   opc == OP_G_FLAG_SET_OP || opc == OP_OVERFLOW_CLEAR_OP) ? CL_FLAG :
                  (opc == OP_BCC || opc == OP_BCS || opc == OP_BEQ ||
                   opc == OP_BNE || opc == OP_BMI || opc == OP_BPL) ? CL_FBR : CL_OTHER;

  assign aluop_in = (opc == OP_CAND) ? BO_AND : (opc == OP_COR) ? BO_OR :
                    (opc == OP_CXOR) ? BO_XOR : (opc == OP_CLD) ? BO_LD :
                    (opc == OP_CST) ? BO_ST : (opc == OP_CNOT) ? BO_NOT :
                    xbit_low ? BO_CLR : BO_SET;

  // Base cycle count per opcode
  assign cyc_base = (opc == OP_CAND) ? CYC_CAND : (opc == OP_COR) ? CYC_COR :
                    (opc == OP_CXOR) ? CYC_CXOR : (opc == OP_CLD) ? CYC_CLD :
                    (opc == OP_CST) ? CYC_CST : (opc == OP_CNOT) ? CYC_CNOT :
                    (cls_in == CL_MBIT) ? CYC_MBIT : (cls_in == CL_ABR) ? CYC_ABR :
                    (cls_in == CL_DBR) ? CYC_DBR : (cls_in == CL_ABIT) ? CYC_ABIT :
                    (opc == OP_BITDP) ? CYC_BITDP : (opc == OP_BITABS) ? CYC_BITABS :
                    (cls_in == CL_TCLR || cls_in == CL_TSET) ? CYC_TST :
                    (cls_in == CL_FLAG) ? CYC_FLAG : (cls_in == CL_FBR) ? CYC_FBR : CYC_OTHER;

  // Branch conditions known at decode
  assign fbr_cond = (opc == OP_BCC) ? ~psw.c : (opc == OP_BCS) ? psw.c :
                    (opc == OP_BEQ) ? psw.z : (opc == OP_BNE) ? ~psw.z :
                    (opc == OP_BMI) ? psw.n : ~psw.n;
  // Accumulator bit branch: high form on 1, low form on 0
  assign imm_taken = (cls_in == CL_FBR) ? fbr_cond :
                     (cls_in == CL_ABR) ? (acc[opc[7:5]] ^ xbit_low) : 1'b0;
  assign dbr_taken = (state == ST_DATA) && (cls_q == CL_DBR) &&
                     (mem_rdata[bsel_q] ^ opc_q[4]);

  // Offset sits after the opcode, or after the direct-page byte
  assign lo_rel = instr_in.op1;
  assign hi_rel = instr_in.op2;
  assign rel_in = (cls_in == CL_DBR) ? hi_rel : lo_rel;

  // Handshake
  assign accept = instr_valid && instr_ready;
  assign instr_ready = (state == ST_IDLE) && ctrl_en;
  assign done = (state != ST_IDLE) && (cnt == 4'h1) && !dbr_taken;
  assign redirect = done && taken_q;
  assign mem_rd = (state == ST_FETCH);
  assign mem_wr = (state == ST_WRITE);
  assign writes = (cls_q == CL_MBIT) || (cls_q == CL_TCLR) || (cls_q == CL_TSET) ||
                  (cls_q == CL_CBIT && (aluop_q == BO_ST || aluop_q == BO_NOT));

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          if (cls_in == CL_CBIT || cls_in == CL_MBIT || cls_in == CL_BIT ||
              cls_in == CL_TCLR || cls_in == CL_TSET || cls_in == CL_DBR) begin
            next_state = ST_FETCH;
          end else begin
            next_state = ST_HOLD;
          end
        end
      end
      ST_FETCH: next_state = ST_DATA;
      ST_DATA: next_state = writes ? ST_WRITE : (done ? ST_IDLE : ST_HOLD);
      ST_WRITE: next_state = done ? ST_IDLE : ST_HOLD;
      ST_HOLD: next_state = done ? ST_IDLE : ST_HOLD;
      default: next_state = ST_IDLE;
    endcase
  end

  // State and remaining-cycle count; a taken branch stretches by two
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
    end else begin
      state <= next_state;
      if (accept) begin
        cnt <= cyc_base - 4'h1 + (imm_taken ? CYC_TAKEN : 4'h0);
      end else if (state != ST_IDLE) begin
        cnt <= cnt - 4'h1 + (dbr_taken ? CYC_TAKEN : 4'h0);
      end
    end
  end

  // Instruction latch
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cls_q <= CL_OTHER;
      aluop_q <= BO_AND;
      opc_q <= 8'h00;
      bsel_q <= 3'h0;
      inv_q <= 1'b0;
      rel_q <= 8'h00;
      pc_next_q <= 16'h0000;
    end else if (accept) begin
      cls_q <= cls_in;
      aluop_q <= aluop_in;
      opc_q <= opc;
      bsel_q <= bsel_in;
      inv_q <= inv_in;
      rel_q <= rel_in;
      pc_next_q <= instr_in.pc_next;
    end
  end

  // Branch target: next-instruction address plus sign-extended offset
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      taken_q <= 1'b0;
      target_pc <= 16'h0000;
    end else if (accept) begin
      taken_q <= imm_taken;
      target_pc <= instr_in.pc_next + {{8{rel_in[7]}}, rel_in};
    end else if (dbr_taken) begin
      taken_q <= 1'b1;
      target_pc <= pc_next_q + {{8{rel_q[7]}}, rel_q};
    end
  end

  bit_alu u_alu (
    .op(aluop_q),
    .sel(bsel_q),
    .inv(inv_q),
    .carry(psw.c),
    .data(mem_rdata),
    .carry_out(alu_carry),
    .data_out(alu_data)
  );

  // Flag results
  assign diff = acc - mem_rdata;
  always_comb begin
    next_psw = psw;
    if (accept && cls_in == CL_FLAG) begin
      case (opc)
        OP_CARRY_CLEAR_OP: next_psw.c = 1'b0;
        OP_CARRY_SET_OP: next_psw.c = 1'b1;
        OP_G_FLAG_CLEAR_OP: next_psw.g = 1'b0;
        OP_G_FLAG_SET_OP: next_psw.g = 1'b1;
        default: next_psw.v = 1'b0;
      endcase
    end else if (state == ST_DATA) begin
      case (cls_q)
        CL_CBIT: next_psw.c = alu_carry;
        CL_BIT: begin
          next_psw.z = ((acc & mem_rdata) == 8'h00);
          next_psw.n = mem_rdata[7];
          next_psw.v = mem_rdata[6];
        end
        CL_TCLR, CL_TSET: begin
          next_psw.n = diff[7];
          next_psw.z = (diff == 8'h00);
        end
        default: next_psw = psw;
      endcase
    end
  end
  assign flag_upd = (accept && cls_in == CL_FLAG) ||
                    ((state == ST_DATA) && (cls_q == CL_CBIT || cls_q == CL_BIT ||
                                            cls_q == CL_TCLR || cls_q == CL_TSET));
  assign acc_upd = accept && (cls_in == CL_ABIT);
  assign acc_new = (opc == OP_ASET) ? (acc | (8'h01 << instr_in.op1[BSEL_HI:BSEL_LO])) :
                   (acc & ~(8'h01 << instr_in.op1[BSEL_HI:BSEL_LO]));  // Fixed opcode, bit in operand

  // Core state; execution wins over a register write in the same cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      psw <= PSW_RST;
      acc <= ACC_RST;
    end else begin
      if (flag_upd) begin
        psw <= next_psw;
      end else if (apb_wr && apb_off == REG_PSW) begin
        psw <= pwdata[7:0];
      end
      if (acc_upd) begin
        acc <= acc_new;
      end else if (apb_wr && apb_off == REG_ACC) begin
        acc <= pwdata[7:0];
      end
    end
  end

  // Memory side: address at decode, write data from the read byte
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_addr <= '0;
      mem_wdata <= 8'h00;
    end else begin
      if (accept) begin
        mem_addr <= addr_in;
      end
      if (state == ST_DATA) begin
        mem_wdata <= (cls_q == CL_TCLR) ? (mem_rdata & ~acc) :
                     (cls_q == CL_TSET) ? (mem_rdata | acc) :
                     alu_data;
      end
    end
  end

  // APB decode; zero wait states, error on unmapped offsets
  assign apb_off = 8'(paddr);
  assign apb_hit = (apb_off == REG_PSW) || (apb_off == REG_ACC) ||
                   (apb_off == REG_CTRL) || (apb_off == REG_STAT);
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite && apb_hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !apb_hit;
  assign rd_mux = (apb_off == REG_PSW) ? {24'h0, psw} :
                  (apb_off == REG_ACC) ? {24'h0, acc} :
                  (apb_off == REG_CTRL) ? {31'h0, ctrl_en} :
                  (apb_off == REG_STAT) ? {16'h0, last_opc, 5'h0, unknown_q,
                                           taken_q, (state != ST_IDLE)} : '0;

  // Read data is captured in the setup cycle, so it is stable in the access phase
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= '0;
      ctrl_en <= CTRL_EN_RST;
      last_opc <= 8'h00;
      unknown_q <= 1'b0;
    end else begin
      if (apb_setup && !pwrite) begin
        prdata <= rd_mux;
      end
      if (apb_wr && apb_off == REG_CTRL) begin
        ctrl_en <= pwdata[CTRL_EN_POS];
      end
      if (accept) begin
        last_opc <= opc;
        unknown_q <= (cls_in == CL_OTHER);
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  carry_and_a: assert property (
    (state == ST_DATA && opc_q == OP_CAND) |=>
      psw.c == ($past(psw.c) & ($past(mem_rdata[bsel_q]) ^ $past(inv_q))))
    else $error("carry AND result wrong");
  carry_or_a: assert property (
    (state == ST_DATA && opc_q == OP_COR) |=>
      psw.c == ($past(psw.c) | ($past(mem_rdata[bsel_q]) ^ $past(inv_q))))
    else $error("carry OR result wrong");
  carry_xor_a: assert property (
    (state == ST_DATA && opc_q == OP_CXOR) |=>
      psw.c == ($past(psw.c) ^ $past(mem_rdata[bsel_q]) ^ $past(inv_q)))
    else $error("carry XOR result wrong");
  carry_load_a: assert property (
    (state == ST_DATA && opc_q == OP_CLD) |=>
      psw.c == ($past(mem_rdata[bsel_q]) ^ $past(inv_q)))
    else $error("carry load result wrong");
  carry_store_a: assert property (
    (accept && opc == OP_CST) |=> ##2 (mem_wr && mem_wdata[bsel_q] == psw.c && $stable(psw)))
    else $error("carry store wrong");
  bit_test_a: assert property (
    (state == ST_DATA && cls_q == CL_BIT) |=>
      (psw.n == $past(mem_rdata[7]) && psw.v == $past(mem_rdata[6]) &&
       psw.z == (($past(acc) & $past(mem_rdata)) == 8'h00)))
    else $error("bit test flags wrong");
  mem_bit_a: assert property (
    (state == ST_DATA && cls_q == CL_MBIT) |=>
      (mem_wr && mem_wdata[bsel_q] == !opc_q[4] && $stable(psw) &&
       (mem_wdata | (8'h01 << bsel_q)) == ($past(mem_rdata) | (8'h01 << bsel_q))))
    else $error("memory bit set or clear wrong");
  acc_bit_a: assert property (
    (accept && (opc == OP_ASET || opc == OP_ACLR)) |=>
      ((acc[$past(instr_in.op1[BSEL_HI:BSEL_LO])] == ($past(opc) == OP_ASET)) && done))
    else $error("accumulator bit op wrong");
  test_set_a: assert property (
    (state == ST_DATA && (cls_q == CL_TSET || cls_q == CL_TCLR)) |=>
      (mem_wdata == ((cls_q == CL_TSET) ? ($past(mem_rdata) | acc) :
                                          ($past(mem_rdata) & ~acc))))
    else $error("test and set or clear write wrong");
  carry_branch_a: assert property (
    (accept && opc == OP_BCC && !psw.c) |=> (!done [*2] ##1 (done && redirect)))
    else $error("taken carry branch timing wrong");
  dp_branch_a: assert property (
    (accept && cls_in == CL_DBR) |=> !done [*3] ##1 (done or (!done [*2] ##1 done)))
    else $error("bit branch timing wrong");

  cover_taken_c: cover property (redirect);
  cover_store_c: cover property (mem_wr && cls_q == CL_CBIT);
  cover_tclr_c: cover property (state == ST_DATA && cls_q == CL_TCLR);
  cover_abr_c: cover property (accept && cls_in == CL_ABR);

endmodule
`default_nettype wire

//--- logic/bit_branch_pkg.sv
`default_nettype none
package bit_branch_pkg;

  // Bus and address widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // Opcodes with a fixed code
  localparam logic [7:0] OP_CAND = 8'h8b;
  localparam logic [7:0] OP_COR = 8'h6b;
  localparam logic [7:0] OP_CXOR = 8'hab;
  localparam logic [7:0] OP_CLD = 8'hcb;
  localparam logic [7:0] OP_CST = 8'heb;
  localparam logic [7:0] OP_CNOT = 8'h4b;
  localparam logic [7:0] OP_ASET = 8'h0b;
  localparam logic [7:0] OP_ACLR = 8'h2b;
  localparam logic [7:0] OP_BITDP = 8'h0c;
  localparam logic [7:0] OP_BITABS = 8'h1c;
  localparam logic [7:0] OP_TCLR = 8'h5c;
  localparam logic [7:0] OP_TSET = 8'h3c;
  localparam logic [7:0] OP_CARRY_CLEAR_OP = 8'h20;
  localparam logic [7:0] OP_CARRY_SET_OP = 8'ha0;
  localparam logic [7:0] OP_G_FLAG_CLEAR_OP = 8'h40;
  localparam logic [7:0] OP_G_FLAG_SET_OP = 8'hc0;
  localparam logic [7:0] OP_OVERFLOW_CLEAR_OP = 8'h80;
  localparam logic [7:0] OP_BCC = 8'h50;
  localparam logic [7:0] OP_BCS = 8'hd0;
  localparam logic [7:0] OP_BEQ = 8'hf0;
  localparam logic [7:0] OP_BNE = 8'h70;
  localparam logic [7:0] OP_BMI = 8'h90;
  localparam logic [7:0] OP_BPL = 8'h10;

  // Low nibbles of the bit-numbered opcode groups
  localparam logic [3:0] NIB_MBIT = 4'h1;
  localparam logic [3:0] NIB_ABR = 4'h2;
  localparam logic [3:0] NIB_DBR = 4'h3;

  // Cycle counts per group; a taken branch adds CYC_TAKEN
  localparam logic [3:0] CYC_CAND = 4'h4;
  localparam logic [3:0] CYC_COR = 4'h5;
  localparam logic [3:0] CYC_CXOR = 4'h5;
  localparam logic [3:0] CYC_CLD = 4'h4;
  localparam logic [3:0] CYC_CST = 4'h6;
  localparam logic [3:0] CYC_CNOT = 4'h5;
  localparam logic [3:0] CYC_BITDP = 4'h4;
  localparam logic [3:0] CYC_BITABS = 4'h5;
  localparam logic [3:0] CYC_MBIT = 4'h4;
  localparam logic [3:0] CYC_ABIT = 4'h2;
  localparam logic [3:0] CYC_FLAG = 4'h2;
  localparam logic [3:0] CYC_TST = 4'h6;
  localparam logic [3:0] CYC_ABR = 4'h4;
  localparam logic [3:0] CYC_DBR = 4'h5;
  localparam logic [3:0] CYC_FBR = 4'h2;
  localparam logic [3:0] CYC_TAKEN = 4'h2;
  localparam logic [3:0] CYC_OTHER = 4'h2;

  // Carry-bit operand layout in the high operand byte
  localparam int INV_POS = 7;
  localparam int BSEL_HI = 6;
  localparam int BSEL_LO = 4;
  localparam int BADDR_HI = 3;

  // Register map (byte offsets) and fields
  localparam logic [7:0] REG_PSW = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam int CTRL_EN_POS = 0;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_REDIR_POS = 1;
  localparam int STAT_UNK_POS = 2;
  localparam int STAT_OPC_LO = 8;

  // Reset values
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic CTRL_EN_RST = 1'b1;

  typedef struct packed {
    logic n;
    logic v;
    logic g;
    logic b;
    logic h;
    logic i;
    logic z;
    logic c;
  } psw_type;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
    logic [15:0] pc_next;
  } instr_type;

  typedef enum logic [3:0] {
    CL_OTHER, CL_CBIT, CL_MBIT, CL_ABIT, CL_BIT, CL_TCLR, CL_TSET,
    CL_FLAG, CL_FBR, CL_ABR, CL_DBR
  } cls_type;

  typedef enum logic [2:0] {
    BO_AND, BO_OR, BO_XOR, BO_LD, BO_ST, BO_SET, BO_CLR, BO_NOT
  } bitop_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_DATA = 5'b00100,
    ST_WRITE = 5'b01000,
    ST_HOLD = 5'b10000
  } state_type;

endpackage
`default_nettype wire

//--- tb/mem_model.sv
`default_nettype none
module mem_model (
  // Clock
  input wire logic clk,
  // Request from the block
  input wire logic rd,
  input wire logic wr,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  // Read data, valid the cycle after a read
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] store [0:65535];
  // Synchronous read; outside a read slot the bus flips so stale data never matches
  always @(posedge clk) begin
    if (wr) begin
      store[addr] <= wdata;
    end
    rdata <= rd ? store[addr] : ~rdata;
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
`default_nettype none
module testbench
  import bit_branch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // One instruction: setup, cycle count, expected state and branch outcome
  typedef struct packed {
    logic [7:0] op, o1, o2, psw, acc, mem;
    logic [15:0] addr;
    logic [3:0] cyc;
    logic [7:0] epsw, eacc, emem;
    logic [3:0] tk;
  } row_type;
  // Stimulus and observed signals
  logic sys_clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic instr_ready, done, redirect, mem_rd, mem_wr, pready, pslverr;
  logic [7:0] paddr = 8'h00, mem_wdata, mem_rdata, acc;
  logic [15:0] target_pc, mem_addr;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  instr_type instr_in = '0;
  psw_type psw;
  int mismatches = 0, tests_run = 0;
  // Fields: op o1 o2 psw acc mem addr cycles psw' acc' mem' taken
  row_type rows [34] = '{
    96'h8b_40_21_01_00_04_0140_4_01_00_04_0,
    96'h8b_40_a1_01_00_04_0140_4_00_00_04_0,
    96'h6b_40_21_00_00_04_0140_5_01_00_04_0,
    96'h6b_40_a1_00_00_00_0140_5_01_00_00_0,
    96'hab_40_21_01_00_04_0140_5_00_00_04_0,
    96'hab_40_a1_01_00_04_0140_5_01_00_04_0,
    96'hcb_40_21_00_00_04_0140_4_01_00_04_0,
    96'hcb_40_a1_01_00_04_0140_4_00_00_04_0,
    96'heb_40_21_01_00_00_0140_6_01_00_04_0,
    96'heb_40_21_00_00_ff_0140_6_00_00_fb_0,
    96'h4b_40_21_00_00_05_0140_5_00_00_01_0,
    96'h0c_40_00_00_3f_c0_0040_4_c2_3f_c0_0,
    96'h1c_40_01_82_40_40_0140_5_40_40_40_0,
    96'hb1_40_00_23_00_ff_0140_4_23_00_df_0,
    96'h01_40_00_00_00_00_0040_4_00_00_01_0,
    96'h0b_ff_00_00_00_00_0040_2_00_80_00_0,
    96'h2b_ff_00_00_ff_00_0040_2_00_7f_00_0,
    96'h20_00_00_ff_00_00_0040_2_fe_00_00_0,
    96'ha0_00_00_00_00_00_0040_2_01_00_00_0,
    96'h40_00_00_ff_00_00_0040_2_df_00_00_0,
    96'hc0_00_00_00_00_00_0040_2_20_00_00_0,
    96'h80_00_00_ff_00_00_0040_2_bf_00_00_0,
    96'h5c_40_01_80_3c_3c_0140_6_02_3c_00_0,
    96'h3c_40_01_02_0f_30_0140_6_80_0f_3f_0,
    96'h50_f0_00_00_00_00_0040_4_00_00_00_1,
    96'hd0_f0_00_00_00_00_0040_2_00_00_00_0,
    96'hf0_f0_00_02_00_00_0040_4_02_00_00_1,
    96'h70_f0_00_02_00_00_0040_2_02_00_00_0,
    96'h90_f0_00_80_00_00_0040_4_80_00_00_1,
    96'h10_f0_00_80_00_00_0040_2_80_00_00_0,
    96'h62_7f_00_00_08_00_0040_6_00_08_00_1,
    96'h72_7f_00_00_08_00_0040_4_00_08_00_0,
    96'hf3_40_80_00_00_7f_0040_7_00_00_7f_1,
    96'he3_40_10_00_00_7f_0040_5_00_00_7f_0};
  // Block under test and its memory
  bit_branch_exec #(.PADDR_W(8)) dut (.sys_clk, .sys_rst, .instr_valid, .instr_ready,
    .instr_in, .done, .redirect, .target_pc, .mem_rd, .mem_wr, .mem_addr, .mem_wdata,
    .mem_rdata, .psw, .acc, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  mem_model mem (.clk(sys_clk), .rd(mem_rd), .wr(mem_wr), .addr(mem_addr),
    .wdata(mem_wdata), .rdata(mem_rdata));
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  task complete_run;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // APB transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Load state, issue one instruction, time it and check its effects
  task automatic run(input row_type r);
    logic [7:0] off;
    int k;
    apb(1'b1, REG_PSW, {24'h0, r.psw});
    apb(1'b1, REG_ACC, {24'h0, r.acc});
    mem.store[r.addr] = r.mem;
    off = (r.op[3:0] == 4'h3) ? r.o2 : r.o1;
    k = 0;
    instr_valid <= 1'b1;
    instr_in <= '{r.op, r.o1, r.o2, 16'h1000};
    do @(negedge sys_clk); while (instr_ready !== 1'b1);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (done !== 1'b1 && k < 16);
    check("cycles", k + 1, {28'h0, r.cyc});
    check("redirect", {31'h0, redirect}, {28'h0, r.tk});
    if (r.tk[0]) begin
      check("target", {16'h0, target_pc}, {16'h0, 16'h1000 + {{8{off[7]}}, off}});
    end
    @(posedge sys_clk);
    @(negedge sys_clk);
    check("psw", {24'h0, psw}, {24'h0, r.epsw});
    check("acc", {24'h0, acc}, {24'h0, r.eacc});
    check("mem", {24'h0, mem.store[r.addr]}, {24'h0, r.emem});
  endtask
  // Watchdog far beyond the expected run length
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    complete_run();
  end
  // Reset values, table of instructions, then refusals and a mid-run reset
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b0, REG_PSW, 32'h0);
    check("psw reset", rd, 32'h0);
    apb(1'b0, REG_CTRL, 32'h0);
    check("ctrl reset", rd & 32'h1, 32'h1);
    foreach (rows[i]) begin
      run(rows[i]);
    end
    run(96'hff_00_00_5a_00_00_0040_2_5a_00_00_0);
    apb(1'b0, REG_STAT, 32'h0);
    check("stat", rd & 32'h0000ff07, 32'h0000ff04);
    apb(1'b1, 8'h10, 32'h1);
    check("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, REG_CTRL, 32'h0);
    @(negedge sys_clk);
    check("ready off", {31'h0, instr_ready}, 32'h0);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    check("ready reset", {31'h0, instr_ready}, 32'h1);
    check("psw clear", {24'h0, psw}, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
